// [pkg/clock_select_regs.vh]
// Register map, fields and reset values of the system clock source and divider block
`ifndef CLOCK_SELECT_REGS_VH
`define CLOCK_SELECT_REGS_VH

`define CSEL_ADDR_W          8
`define CSEL_DATA_W          8

`define CSEL_CTRL_OFFSET     8'h00
`define CSEL_STATUS_OFFSET   8'h04

`define CSEL_SRC_LSB         0
`define CSEL_SRC_MSB         1
`define CSEL_DIV_LSB         4
`define CSEL_DIV_MSB         6

`define CSEL_STAT_PEND_BIT   2
`define CSEL_STAT_CLK_BIT    3

`define CSEL_SRC_HFOSC       2'h0
`define CSEL_SRC_EXT         2'h1
`define CSEL_SRC_LFOSC       2'h2
`define CSEL_SRC_RSVD        2'h3

`define CSEL_SRC_RESET       2'h0
`define CSEL_DIV_RESET       3'h3

`endif

// [logic/clock_edge_sync.v]
// Two-flop synchroniser with edge detection for one asynchronous clock source
`timescale 1ns/1ps
module clock_edge_sync (
    input  wire clk_sys,
    input  wire rst_n,
    input  wire asyncIn,
    output reg  level,
    output reg  rise,
    output reg  fall
);
    reg stage1;
    reg stage2;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            level  <= 1'b0;
            rise   <= 1'b0;
            fall   <= 1'b0;
        end else begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            level  <= stage2;
            rise   <= stage2 & ~level;
            fall   <= ~stage2 & level;
        end
    end
endmodule

// [logic/system_clock_source_select_divider.v]
// System clock source selection and power-of-two divider with register port
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module system_clock_source_select_divider (
    input  wire                     clk_sys,
    input  wire                     rst_n,
    input  wire                     hfOscIn,
    input  wire                     external_clock_input,
    input  wire                     lfOscIn,
    input  wire [`CSEL_ADDR_W-1:0]  addr,
    input  wire [`CSEL_DATA_W-1:0]  wrData,
    input  wire                     wrStrobe,
    input  wire                     rdStrobe,
    output reg  [`CSEL_DATA_W-1:0]  rdData,
    output reg                      system_clock,
    output reg                      extClockSync,
    output reg  [1:0]               activeSource,
    output reg  [2:0]               activeDivide
);
    // Written fields of the control register, then the source edge counter
    reg  [1:0] source_choice_code;
    reg  [2:0] source_divide_code;
    reg  [6:0] edgeCount;

    wire       hfRise;
    wire       hfFall;
    wire       extLevel;
    wire       extRise;
    wire       extFall;
    wire       lfRise;
    wire       lfFall;

    reg        srcRise;
    reg        srcFall;
    reg        periodEnd;
    reg        changePending;
    reg  [1:0] next_activeSource;
    reg  [2:0] next_activeDivide;
    reg  [6:0] next_edgeCount;
    reg        next_systemClock;
    reg  [`CSEL_DATA_W-1:0] next_rdData;

    // Source edges needed per half period; divide by 1 follows the source level
    function [6:0] halfEdges;
        input [2:0] code;
        begin
            case (code)
                3'h1:    halfEdges = 7'h01;
                3'h2:    halfEdges = 7'h02;
                3'h3:    halfEdges = 7'h04;
                3'h4:    halfEdges = 7'h08;
                3'h5:    halfEdges = 7'h10;
                3'h6:    halfEdges = 7'h20;
                3'h7:    halfEdges = 7'h40;
                default: halfEdges = 7'h01;
            endcase
        end
    endfunction

    clock_edge_sync hfSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .asyncIn (hfOscIn),
        .level   (),
        .rise    (hfRise),
        .fall    (hfFall)
    );

    clock_edge_sync extSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .asyncIn (external_clock_input),
        .level   (extLevel),
        .rise    (extRise),
        .fall    (extFall)
    );

    clock_edge_sync lfSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .asyncIn (lfOscIn),
        .level   (),
        .rise    (lfRise),
        .fall    (lfFall)
    );

    // Edges of the source that is currently driving the output; levels are not
    // needed, since following a level directly could cut a phase after a switch
    always @* begin
        case (activeSource)
            `CSEL_SRC_HFOSC: begin
                srcRise  = hfRise;
                srcFall  = hfFall;
            end
            `CSEL_SRC_EXT: begin
                srcRise  = extRise;
                srcFall  = extFall;
            end
            `CSEL_SRC_LFOSC: begin
                srcRise  = lfRise;
                srcFall  = lfFall;
            end
            default: begin
                srcRise  = 1'b0;
                srcFall  = 1'b0;
            end
        endcase
    end

    // Reserved source code keeps the running source rather than stopping the clock
    always @* begin
        changePending = (source_divide_code != activeDivide) ||
                        ((source_choice_code != activeSource) &&
                         (source_choice_code != `CSEL_SRC_RSVD));
        periodEnd = srcRise && !system_clock &&
                    ((activeDivide == 3'h0) ||
                     (edgeCount == halfEdges(activeDivide) - 7'h01));
    end

    always @* begin
        next_activeSource = activeSource;
        next_activeDivide = activeDivide;
        next_edgeCount    = edgeCount;
        next_systemClock  = system_clock;
        if (periodEnd && changePending) begin
            // Switch only at the end of a full low phase: the old high phase is
            // complete and the new one starts on a fresh edge, so only the low
            // phase is stretched.
            if (source_choice_code != `CSEL_SRC_RSVD) begin
                next_activeSource = source_choice_code;
            end
            next_activeDivide = source_divide_code;
            next_edgeCount    = 7'h00;
            next_systemClock  = 1'b0;
        end else if (activeDivide == 3'h0) begin
            if (srcRise) begin
                next_systemClock = 1'b1;
            end else if (srcFall) begin
                next_systemClock = 1'b0;
            end
        end else if (srcRise) begin
            if (edgeCount == halfEdges(activeDivide) - 7'h01) begin
                next_edgeCount   = 7'h00;
                next_systemClock = ~system_clock;
            end else begin
                next_edgeCount = edgeCount + 7'h01;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            activeSource <= `CSEL_SRC_RESET;
            activeDivide <= `CSEL_DIV_RESET;
            edgeCount    <= 7'h00;
            system_clock <= 1'b0;
        end else begin
            activeSource <= next_activeSource;
            activeDivide <= next_activeDivide;
            edgeCount    <= next_edgeCount;
            system_clock <= next_systemClock;
        end
    end

    // Synchronised external clock for peripherals; same flops in every mode
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            extClockSync <= 1'b0;
        end else begin
            extClockSync <= extLevel;
        end
    end

    // Register port
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            source_choice_code <= `CSEL_SRC_RESET;
            source_divide_code <= `CSEL_DIV_RESET;
        end else if (wrStrobe && addr == `CSEL_CTRL_OFFSET) begin
            // Reserved bits are dropped here
            source_choice_code <= wrData[`CSEL_SRC_MSB:`CSEL_SRC_LSB];
            source_divide_code <= wrData[`CSEL_DIV_MSB:`CSEL_DIV_LSB];
        end
    end

    always @* begin
        next_rdData = 8'h00;
        if (rdStrobe) begin
            case (addr)
                `CSEL_CTRL_OFFSET: begin
                    next_rdData[`CSEL_SRC_MSB:`CSEL_SRC_LSB] = source_choice_code;
                    next_rdData[`CSEL_DIV_MSB:`CSEL_DIV_LSB] = source_divide_code;
                end
                `CSEL_STATUS_OFFSET: begin
                    next_rdData[`CSEL_SRC_MSB:`CSEL_SRC_LSB] = activeSource;
                    next_rdData[`CSEL_DIV_MSB:`CSEL_DIV_LSB] = activeDivide;
                    next_rdData[`CSEL_STAT_PEND_BIT]         = changePending;
                    next_rdData[`CSEL_STAT_CLK_BIT]          = system_clock;
                end
                default: begin
                    next_rdData = 8'h00;
                end
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rdData <= 8'h00;
        end else begin
            rdData <= next_rdData;
        end
    end
endmodule

// [dv/clock_select_checker.sv]
// Port assertions for the clock source select and divider block
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module clock_select_checker (
    input wire                    clk_sys,
    input wire                    rst_n,
    input wire                    external_clock_input,
    input wire [`CSEL_ADDR_W-1:0] addr,
    input wire                    rdStrobe,
    input wire [`CSEL_DATA_W-1:0] rdData,
    input wire                    system_clock,
    input wire                    extClockSync,
    input wire [1:0]              activeSource,
    input wire [2:0]              activeDivide
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_rstVal; $rose(rst_n) |-> activeDivide == 3'h3 && !system_clock; endproperty
    property p_noRsvd; activeSource != 2'h3; endproperty
    // Synchroniser is only trusted once it has run five clean edges
    property p_extSync; rst_n [*5] |-> extClockSync == $past(external_clock_input, 4); endproperty
    property p_hi; $rose(system_clock) |-> system_clock [*3]; endproperty
    property p_lo; $fell(system_clock) |-> !system_clock [*3]; endproperty
    property p_chgLow; $changed({activeSource, activeDivide}) |-> !system_clock; endproperty
    property p_stat; rdStrobe && addr == `CSEL_STATUS_OFFSET |=>
        rdData[6:4] == $past(activeDivide) && rdData[1:0] == $past(activeSource); endproperty
    property p_rsvd; rdStrobe && addr == 8'h00 |=> rdData[7] == 1'b0 && rdData[3:2] == 2'h0;
    endproperty
    property p_unmap; rdStrobe && addr != 8'h00 && addr != 8'h04 |=> rdData == 8'h00; endproperty
    a_rstVal: assert property (p_rstVal) else $error("bad state after reset");
    a_noRsvd: assert property (p_noRsvd) else $error("reserved source applied");
    a_extSync: assert property (p_extSync) else $error("external sync lag wrong");
    a_hi: assert property (p_hi) else $error("short high phase");
    a_lo: assert property (p_lo) else $error("short low phase");
    a_chgLow: assert property (p_chgLow) else $error("switch while clock high");
    a_stat: assert property (p_stat) else $error("status read wrong");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    c_ext: cover property (activeSource == 2'h1);
    c_lf: cover property (activeSource == 2'h2);
    c_div7: cover property (activeDivide == 3'h7);
endmodule
bind system_clock_source_select_divider clock_select_checker chk_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .external_clock_input(external_clock_input), .addr(addr),
    .rdStrobe(rdStrobe), .rdData(rdData), .system_clock(system_clock),
    .extClockSync(extClockSync), .activeSource(activeSource), .activeDivide(activeDivide));

// [dv/test_system_clock_source_select_divider.sv]
// Self-checking bench for the clock source select and divider
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module test_system_clock_source_select_divider;
    logic       clk_sys = 0;
    logic       rst_n = 0;
    logic       hfOscIn = 0;
    logic       external_clock_input = 0;
    logic       lfOscIn = 0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic       wrStrobe = 0;
    logic       rdStrobe = 0;
    wire  [7:0] rdData;
    wire        system_clock;
    wire  [1:0] activeSource;
    wire  [2:0] activeDivide;
    wire        extClockSync;
    logic [3:0] extHist = 4'h0;
    int         cyc = 0;
    int         error_cnt = 0;
    int         checked = 0;
    system_clock_source_select_divider uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .hfOscIn(hfOscIn), .external_clock_input(external_clock_input), .lfOscIn(lfOscIn),
        .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .system_clock(system_clock), .extClockSync(extClockSync),
        .activeSource(activeSource), .activeDivide(activeDivide));
    initial forever #5 clk_sys = ~clk_sys;
    // Sources: periods 8, 12 and 20 cycles, all slower than clk_sys/2
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        hfOscIn <= (cyc % 8) < 4;
        external_clock_input <= (cyc % 12) < 6;
        lfOscIn <= (cyc % 20) < 10;
        // Pin as the block samples it; the synced copy trails by three more edges
        extHist <= {extHist[2:0], external_clock_input};
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        #1 chk(rdData, e);
    endtask
    task waitLvl(input logic v, inout int n);
        while (system_clock !== v && n < 4000) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask
    // Skips the partial period, then counts one full period
    task msr(input int exp);
        int n;
        begin
            n = 0;
            waitLvl(1'b0, n);
            waitLvl(1'b1, n);
            n = 0;
            waitLvl(1'b0, n);
            waitLvl(1'b1, n);
            chk(n, exp);
        end
    endtask
    task setCtl(input logic [7:0] d);
        int n;
        begin
            n = 0;
            wr(`CSEL_CTRL_OFFSET, d);
            while ({activeDivide, activeSource} !== {d[6:4], d[1:0]} && n < 3000) begin
                @(posedge clk_sys);
                #1 n++;
            end
            chk({activeDivide, activeSource}, {d[6:4], d[1:0]});
        end
    endtask
    task finish_test;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        finish_test;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`CSEL_CTRL_OFFSET, 8'h30);
        chk({activeDivide, activeSource}, 5'h0c);
        msr(64);
        for (int i = 0; i < 8; i++) begin
            setCtl({1'b0, i[2:0], 4'h0});
            msr(8 << i);
        end
        wr(`CSEL_CTRL_OFFSET, 8'hff);
        rd(`CSEL_CTRL_OFFSET, 8'h73);
        repeat (2000) @(posedge clk_sys);
        #1 chk(activeSource, 2'h0);
        repeat (24) begin
            @(posedge clk_sys);
            #1 chk(extClockSync, extHist[3]);
        end
        setCtl(8'h01);
        msr(12);
        setCtl(8'h02);
        msr(20);
        setCtl(8'h11);
        msr(24);
        // Read lands two edges into a twelve-cycle high phase
        rd(`CSEL_STATUS_OFFSET, 8'h19);
        rd(8'h10, 8'h00);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`CSEL_CTRL_OFFSET, 8'h30);
        chk({activeDivide, activeSource}, 5'h0c);
        msr(64);
        finish_test;
    end
endmodule
